/* File: fpd_params.svh */
// constants for the fine pwm converter: offsets, fields, reset values, timing
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH

// register indices as printed; byte address is four times the index
`define FPD_IDX_LOW        12'h0D2
`define FPD_IDX_HIGH       12'h0D3
`define FPD_IDX_CTRL       12'h0E0
`define FPD_IDX_STAT       12'h0E1
`define FPD_ADDR_LOW       12'h348
`define FPD_ADDR_HIGH      12'h34C
`define FPD_ADDR_CTRL      12'h380
`define FPD_ADDR_STAT      12'h384

// field positions
`define FPD_HI_EN_BIT      7
`define FPD_HI_RSVD_BIT    6
`define FPD_CTRL_LATCH_BIT 0

// reset values
`define FPD_RST_VALUE      14'h0000
`define FPD_RST_ENABLE     1'b0
`define FPD_RST_LATCH      1'b1

// timing: pwm clock is the core clock divided by four
`define FPD_CLK_NS         5
`define FPD_PWM_DIV        4
`define FPD_PWM_NS         (`FPD_CLK_NS * `FPD_PWM_DIV)
`define FPD_BASE_PERIOD    128

// axi answers
`define FPD_RESP_OKAY      2'h0
`define FPD_RESP_SLVERR    2'h2

`endif

/* File: fpd_pkg.sv */
// types shared by the fine pwm converter
package fpd_pkg;

  typedef enum logic [1:0] {
    FPD_WR_IDLE = 2'b00,
    FPD_WR_ADDR = 2'b01,
    FPD_WR_DATA = 2'b10,
    FPD_WR_RESP = 2'b11
  } fpd_wr_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } fpd_wr_type;

  typedef struct packed {
    logic        pending;
    logic        dac_out;
    logic        stretch_pend;
    logic [13:0] count;
  } fpd_stat_type;

endpackage

/* File: fpd_pwm_dac.sv */
// fine pwm converter: 14-bit dual-rate pwm dac with axi4-lite register slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "fpd_params.svh"

// Behaviour
// - free 14-bit counter on core clock over four
// - counter may ripple; built synchronous here
// - latch value at wrap unless low pending
// - output set when low counter bits wrap
// - output cleared when value top matches counter
// - base period is 128 pwm clocks
// - stretch from seven ored value-counter terms
// - stretch holds output high one extra clock
// - low register bits 6..0 reversed value 0..6
// - high register: enable, reserved, value 13..8
// - no polarity inversion option
// - pin low if latch bit or dac low
module fpd_pwm_dac
  import fpd_pkg::*;
#(
  parameter int VAL_W = 14,
  parameter int AW    = 12
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  // axi4-lite write address
  input  wire logic [AW-1:0] i_awaddr,
  input  wire logic          i_awvalid,
  output logic               o_awready,
  // axi4-lite write data
  input  wire logic [31:0]   i_wdata,
  input  wire logic [3:0]    i_wstrb,
  input  wire logic          i_wvalid,
  output logic               o_wready,
  // axi4-lite write response
  output logic [1:0]         o_bresp,
  output logic               o_bvalid,
  input  wire logic          i_bready,
  // axi4-lite read address
  input  wire logic [AW-1:0] i_araddr,
  input  wire logic          i_arvalid,
  output logic               o_arready,
  // axi4-lite read data
  output logic [31:0]        o_rdata,
  output logic [1:0]         o_rresp,
  output logic               o_rvalid,
  input  wire logic          i_rready,
  // shared open-drain output pin
  input  wire logic          i_shared_output_pin,
  output logic               o_shared_output_pin,
  output logic               o_shared_output_pin_oe
);

  localparam int LOW_W = 7;

  fpd_wr_state_type wr_state_r;
  fpd_wr_type       wr_r;
  logic [1:0]       pre_r;
  logic             tick;
  logic [13:0]      cnt_r;
  logic [13:0]      cnt_nxt;
  logic [13:0]      prog_r;
  logic [13:0]      op_r;
  logic [13:0]      op_eff;
  logic             en_r;
  logic             latch_r;
  logic             pend_r;
  logic             out_r;
  logic             str_pend_r;
  logic             wrap;
  logic             load;
  logic             match;
  logic [6:0]       terms;
  logic             stretch;
  logic             dac_out;
  logic             wr_go;
  logic             aw_hs;
  logic             w_hs;
  logic             b_hs;
  logic             wr_low;
  logic             wr_high;
  logic             wr_ctrl;
  logic [7:0]       rd_byte;
  logic             rd_hit;
  fpd_stat_type     stat;

  // ---------------- pwm clock and shared counter ----------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_r <= 2'h0;
    end else begin
      pre_r <= pre_r + 2'h1;
    end
  end

  assign tick    = (pre_r == 2'(`FPD_PWM_DIV - 1));
  assign cnt_nxt = cnt_r + 14'h0001;

  // one synchronous counter instead of a ripple chain so the compare never sees
  // a settling value; the cost is a 14-bit carry chain at 200 MHz
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 14'h0000;
    end else if (tick) begin
      cnt_r <= cnt_nxt;
    end
  end

  // ---------------- register writes ----------------
  // a channel is taken only at the edge where its own valid and ready are both high
  assign aw_hs = i_awvalid && o_awready;
  assign w_hs  = i_wvalid && o_wready;
  assign b_hs  = o_bvalid && i_bready;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_state_r <= FPD_WR_IDLE;
      wr_r       <= '0;
    end else begin
      unique case (wr_state_r)
        FPD_WR_IDLE: begin
          if (aw_hs && w_hs) begin
            wr_r       <= '{addr: i_awaddr, data: i_wdata, strb: i_wstrb};
            wr_state_r <= FPD_WR_RESP;
          end else if (aw_hs) begin
            wr_r.addr  <= i_awaddr;
            wr_state_r <= FPD_WR_ADDR;
          end else if (w_hs) begin
            wr_r.data  <= i_wdata;
            wr_r.strb  <= i_wstrb;
            wr_state_r <= FPD_WR_DATA;
          end
        end
        FPD_WR_ADDR: begin
          if (w_hs) begin
            wr_r.data  <= i_wdata;
            wr_r.strb  <= i_wstrb;
            wr_state_r <= FPD_WR_RESP;
          end
        end
        FPD_WR_DATA: begin
          if (aw_hs) begin
            wr_r.addr  <= i_awaddr;
            wr_state_r <= FPD_WR_RESP;
          end
        end
        FPD_WR_RESP: begin
          if (b_hs) begin
            wr_state_r <= FPD_WR_IDLE;
          end
        end
      endcase
    end
  end

  // write takes effect on entry to the response state
  assign wr_go   = (wr_state_r == FPD_WR_RESP) && !o_bvalid && wr_r.strb[0];
  assign wr_low  = wr_go && (wr_r.addr == `FPD_ADDR_LOW);
  assign wr_high = wr_go && (wr_r.addr == `FPD_ADDR_HIGH);
  assign wr_ctrl = wr_go && (wr_r.addr == `FPD_ADDR_CTRL);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `FPD_RESP_OKAY;
    end else begin
      // a ready stands while its channel may still be taken, so nothing is lost unseen
      o_awready <= ((wr_state_r == FPD_WR_IDLE || wr_state_r == FPD_WR_DATA) && !aw_hs)
                   || (wr_state_r == FPD_WR_RESP && b_hs);
      o_wready  <= ((wr_state_r == FPD_WR_IDLE || wr_state_r == FPD_WR_ADDR) && !w_hs)
                   || (wr_state_r == FPD_WR_RESP && b_hs);
      if (wr_state_r == FPD_WR_RESP && !o_bvalid) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (wr_r.addr == `FPD_ADDR_LOW || wr_r.addr == `FPD_ADDR_HIGH ||
                     wr_r.addr == `FPD_ADDR_CTRL || wr_r.addr == `FPD_ADDR_STAT)
                    ? `FPD_RESP_OKAY : `FPD_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // value bits: low register stores bit 7 straight and 6..0 reversed
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prog_r <= `FPD_RST_VALUE;
      en_r   <= `FPD_RST_ENABLE;
    end else if (wr_low) begin
      prog_r[7] <= wr_r.data[7];
      for (int i = 0; i < LOW_W; i++) begin
        prog_r[i] <= wr_r.data[6-i];
      end
    end else if (wr_high) begin
      en_r         <= wr_r.data[`FPD_HI_EN_BIT];
      prog_r[13:8] <= wr_r.data[5:0];
    end
  end

  // a low write opens a pair; only the high write closes it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r <= 1'b0;
    end else if (wr_low) begin
      pend_r <= 1'b1;
    end else if (wr_high) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_r <= `FPD_RST_LATCH;
    end else if (wr_ctrl) begin
      latch_r <= wr_r.data[`FPD_CTRL_LATCH_BIT];
    end
  end

  // ---------------- operative latch and compare ----------------
  assign wrap   = tick && (cnt_nxt[6:0] == 7'h00);
  assign load   = wrap && !pend_r;
  assign op_eff = load ? prog_r : op_r;
  assign match  = tick && (op_eff[13:7] == cnt_nxt[6:0]);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_r <= `FPD_RST_VALUE;
    end else if (load) begin
      op_r <= prog_r;
    end
  end

  // term k: value bit 6-k with counter[7+k:7] equal to one then k zeros
  for (genvar k = 0; k < LOW_W; k++) begin : g_term
    localparam logic [6:0] MASK = 7'((2 << k) - 1);
    localparam logic [6:0] PATT = 7'(1 << k);
    assign terms[k] = op_eff[6-k] && ((cnt_nxt[13:7] & MASK) == PATT);
  end
  assign stretch = |terms;

  // match at the wrap with no stretch means zero duty, so clear beats set there
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_r      <= 1'b1;
      str_pend_r <= 1'b0;
    end else if (tick) begin
      str_pend_r <= match && stretch;
      if (str_pend_r && !wrap) begin
        out_r <= 1'b0;
      end else if (match && !stretch) begin
        out_r <= 1'b0;
      end else if (wrap) begin
        out_r <= 1'b1;
      end
    end
  end

  // inversion only by complementing the value in software
  assign dac_out = en_r ? out_r : 1'b1;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_shared_output_pin    <= 1'b0;
      o_shared_output_pin_oe <= 1'b0;
    end else begin
      o_shared_output_pin    <= 1'b0;
      o_shared_output_pin_oe <= !(latch_r && dac_out);
    end
  end

  // ---------------- register reads ----------------
  assign stat = '{pending: pend_r, dac_out: dac_out, stretch_pend: str_pend_r, count: cnt_r};

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (i_araddr)
      `FPD_ADDR_LOW: begin
        rd_byte[7] = prog_r[7];
        for (int i = 0; i < LOW_W; i++) begin
          rd_byte[6-i] = prog_r[i];
        end
      end
      `FPD_ADDR_HIGH: begin
        rd_byte = {en_r, 1'b0, prog_r[13:8]};
      end
      `FPD_ADDR_CTRL: begin
        rd_byte = {7'h00, latch_r};
      end
      `FPD_ADDR_STAT: begin
        rd_byte = 8'h00;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `FPD_RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !o_arready;
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp  <= rd_hit ? `FPD_RESP_OKAY : `FPD_RESP_SLVERR;
        o_rdata  <= (i_araddr == `FPD_ADDR_STAT) ? {15'h0000, stat} : {24'h000000, rd_byte};
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- checks ----------------
  chk_prescale_div: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    tick |=> !tick [*3] ##1 tick)
    else $error("pwm clock is not core clock over four");

  chk_count_step: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $changed(cnt_r) |-> $past(tick) && (cnt_r == 14'($past(cnt_r) + 14'h0001)))
    else $error("shared counter moved off a pwm tick");

  chk_load_wrap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $changed(op_r) |-> (cnt_r[6:0] == 7'h00) && !$past(pend_r))
    else $error("operative value loaded off the wrap or mid pair");

  chk_rise_wrap: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(out_r) |-> (cnt_r[6:0] == 7'h00))
    else $error("output set away from the wrap");

  chk_fall_match: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(out_r) && !$past(str_pend_r) |-> (op_r[13:7] == cnt_r[6:0]))
    else $error("output cleared without a match");

  chk_stretch_one: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $fell(out_r) && $past(str_pend_r) |-> (7'(op_r[13:7] + 7'h01) == cnt_r[6:0]))
    else $error("stretched edge not one pwm clock late");

  chk_stretch_src: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    $rose(str_pend_r) |-> $past(stretch) && $past(match))
    else $error("stretch flag without a stretch term");

  chk_pin_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!latch_r || (en_r && !out_r)) |=> o_shared_output_pin_oe)
    else $error("pin not pulled low");

  chk_disabled_one: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!en_r && latch_r) |=> !o_shared_output_pin_oe)
    else $error("disabled converter still drives the pin");

  chk_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_arvalid && o_arready && i_araddr == `FPD_ADDR_HIGH) |=> o_rvalid && !o_rdata[6])
    else $error("reserved high bit read as one");

endmodule
`default_nettype wire

/* File: fpd_integrator.sv */
// far-side model: pulled-up open-drain pin feeding an analog integrator
`timescale 1ns/10ps
`default_nettype none
module fpd_integrator (
  // clock and control
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  // pin drive from the converter
  input  wire logic        i_out,
  input  wire logic        i_oe,
  // pin level and integrated high time in core clocks
  output logic             o_level,
  output logic [31:0]      o_acc
);
  // released pin floats up to the pull-up; no drive means high
  assign o_level = i_oe ? i_out : 1'b1;
  // the integrator only sees the average, so counting high clocks is enough
  always_ff @(posedge i_clk) begin
    if (i_clr)
      o_acc <= 32'h0;
    else if (o_level)
      o_acc <= o_acc + 32'h1;
  end
endmodule
`default_nettype wire

/* File: fpd_pwm_dac_test.sv */
// self-checking bench for the fine pwm converter
`timescale 1ns/10ps
`default_nettype none
`include "fpd_params.svh"
module fpd_pwm_dac_test;
  import fpd_pkg::*;
  logic        i_clk, i_arst_n, awvalid, wvalid, bready, arvalid, rready, clr;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rnd, d;
  logic [3:0]  wstrb;
  logic [1:0]  r;
  logic [7:0]  lo, hi;
  logic        pend, lat, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        pin_out, pin_oe, level;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] o_rdata, acc;
  int          op, num_errors, checks;
  logic [7:0]  tbl [4] = '{8'h80, 8'hFF, 8'hA5, 8'h81};

  fpd_pwm_dac i_fpd_pwm_dac (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready),
    .i_shared_output_pin(level), .o_shared_output_pin(pin_out),
    .o_shared_output_pin_oe(pin_oe));
  fpd_integrator i_fpd_integrator (.i_clk(i_clk), .i_clr(clr), .i_out(pin_out),
    .i_oe(pin_oe), .o_level(level), .o_acc(acc));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // operative value as assembled from the two byte registers
  function automatic int val();
    int v;
    v = {hi[5:0], lo[7], 7'h00};
    for (int i = 0; i < 7; i++) v += lo[6-i] << i;
    return v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] b);
    logic done;
    logic [1:0] er;
    rnd = lfsr(rnd);
    er = `FPD_RESP_OKAY;
    @(posedge i_clk);
    awaddr <= a; wdata <= {rnd[31:8], b}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge i_clk);
      if (awvalid && o_awready) awvalid <= 1'b0;
      if (wvalid && o_wready) wvalid <= 1'b0;
      if (bready && o_bvalid) begin
        r = o_bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    case (a)
      `FPD_ADDR_LOW: begin lo = b; pend = 1'b1; end
      `FPD_ADDR_HIGH: begin hi = b & 8'hBF; pend = 1'b0; op = val(); end
      `FPD_ADDR_CTRL: lat = b[0];
      default: er = `FPD_RESP_SLVERR;
    endcase
    chk(r, er);
  endtask
  task automatic axr(input logic [11:0] a);
    logic done;
    @(posedge i_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge i_clk);
      if (arvalid && o_arready) arvalid <= 1'b0;
      if (rready && o_rvalid) begin
        d = o_rdata;
        r = o_rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // waits past one base period so the next wrap has loaded the value
  task automatic duty(input int n);
    int e;
    repeat (600) @(posedge i_clk);
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (n) @(posedge i_clk);
    #1;
    // a short window sees no stretch only because the table leaves low bits zero
    e = !lat ? 0 : !hi[7] ? n : (n == 512) ? 4 * (op >> 7) : 4 * op;
    chk(acc, 32'(e));
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    // about 76k clocks of tests, mostly the one full super-cycle
    repeat (95000) @(posedge i_clk);
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    summarize();
  end
  initial begin
    i_arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; clr = 1'b0; awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0;
    wstrb = 4'h0; lo = 8'h0; hi = 8'h0; pend = 1'b0; lat = 1'b1; op = 0;
    rnd = 32'hE17D; num_errors = 0; checks = 0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    axr(`FPD_ADDR_LOW); chk(d, 32'h0);
    axr(`FPD_ADDR_HIGH); chk(d, 32'h0);
    axr(`FPD_ADDR_CTRL); chk(d, 32'h1);
    axr(12'h100); chk({d[29:0], r}, {30'h0, `FPD_RESP_SLVERR});
    axw(12'h100, 8'hFF);
    duty(512);
    foreach (tbl[k]) begin
      axw(`FPD_ADDR_HIGH, tbl[k]);
      axr(`FPD_ADDR_HIGH); chk(d, {24'h0, hi});
      duty(512);
    end
    axw(`FPD_ADDR_LOW, 8'h80);
    axr(`FPD_ADDR_STAT); chk(d[16], pend);
    axr(`FPD_ADDR_LOW); chk(d, 32'h80);
    duty(512);
    axw(`FPD_ADDR_HIGH, 8'h81);
    axr(`FPD_ADDR_STAT); chk(d[16], pend);
    duty(512);
    axw(`FPD_ADDR_HIGH, 8'h01);
    duty(512);
    axw(`FPD_ADDR_HIGH, 8'h90);
    axw(`FPD_ADDR_CTRL, 8'h00);
    duty(512);
    axw(`FPD_ADDR_CTRL, 8'h01);
    rnd = lfsr(rnd);
    axw(`FPD_ADDR_LOW, rnd[7:0]);
    axw(`FPD_ADDR_HIGH, {2'b10, rnd[13:8]});
    // one full super-cycle: total high time is the whole 14-bit value
    duty(65536);
    summarize();
  end
endmodule
`default_nettype wire
